// ==== pg_delay_pkg.sv ====
/*
 Constants, types and threshold decode for the paged power-good window
 and on/off delay registers. Assumes a 100 MHz single clock.
*/
package pg_delay_pkg;
   localparam logic [7:0] CMD_PG_WINDOW = 8'hd7;
   localparam logic [7:0] CMD_ON_OFF_DELAY = 8'hd8;
   localparam logic [7:0] PAGE_CH1 = 8'h00;
   localparam logic [7:0] PAGE_CH2 = 8'h01;
   localparam logic [7:0] PAGE_BOTH = 8'h11;
   localparam int SEL_LSB = 0;
   localparam int ON_LSB = 5;
   localparam int OFF_LSB = 1;
   localparam logic [1:0] PG_SEL_RESET = 2'h1;
   localparam logic [2:0] RATIO_RESET = 3'h0;
   localparam int FIX_OV_BIT = 13;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_ON_WAIT_NS = 50000;
   localparam int MIN_ON_WAIT_CYCLES = (MIN_ON_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COUNT_W = 24;
   localparam int RISE_W = 20;
   // Limits in tenths of a percent, signed; fixed overvoltage limits in mV
   localparam logic signed [9:0] PCT_168 = 10'sh0a8;
   localparam logic signed [9:0] PCT_125 = 10'sh07d;
   localparam logic signed [9:0] PCT_120 = 10'sh078;
   localparam logic signed [9:0] PCT_070 = 10'sh046;
   localparam logic signed [9:0] PCT_290 = 10'sh122;
   localparam logic signed [9:0] PCT_230 = 10'sh0e6;
   localparam logic [9:0] OV_FIXED_800_MV = 10'h320;
   localparam logic [9:0] OV_FIXED_700_MV = 10'h2bc;

   typedef enum logic [1:0] {
      SEQ_OFF = 2'h0,
      SEQ_ON_WAIT = 2'h1,
      SEQ_ON = 2'h2,
      SEQ_OFF_WAIT = 2'h3
   } seq_e;

   typedef struct packed {
      logic signed [9:0] uv;
      logic signed [9:0] pg_low;
      logic signed [9:0] pg_high;
      logic signed [9:0] ov;
      logic [9:0] ov_mv;
   } limits_s;

   // Tracking limit is zero while the fixed absolute limit is in force
   function automatic limits_s decode_limits(input logic [1:0] sel, input logic fixed);
      limits_s l;
      l.uv = sel[1] ? -PCT_290 : (sel[0] ? -PCT_120 : -PCT_168);
      l.pg_low = sel[1] ? -PCT_230 : (sel[0] ? -PCT_070 : -PCT_125);
      l.pg_high = (sel == 2'h0) ? PCT_125 : PCT_070;
      l.ov = fixed ? 10'sh000 : (sel[0] ? PCT_120 : PCT_168);
      l.ov_mv = !fixed ? 10'h000 : (sel[0] ? OV_FIXED_700_MV : OV_FIXED_800_MV);
      return l;
   endfunction : decode_limits
endpackage : pg_delay_pkg

// ==== pg_window_and_onoff_delay_regs.sv ====
/*
 Two paged configuration registers per channel (threshold window select,
 on/off delay ratios) with follower lockout and the on/off delay sequencer.
 Assumes a PMBus front end that decodes PAGE and command code and presents
 one access per cmd_valid pulse, and nonvolatile images held outside.
*/
// What this block does
// - Page 0 selects channel one, 1 channel two, 11 both at once.
// - Writes aimed at a follower channel are discarded, contents kept.
// - Follower access is NACKed, sets invalid command fault, asserts alert.
// - Follower forces turn-on wait to 50 us and turn-off wait to zero.
// - Select 00 and 01 give their undervoltage, window and tracking limits.
// - Select 10 and 11 give -29, -23, +7 and 16.8 or 12.0 percent.
// - Fixed-overvoltage option replaces limit by 800 or 700 mV by select bit 0.
// - Turn-on wait is rise time times on-delay field bits 7:5.
// - Turn-off wait is rise time times off-delay field bits 3:1.
// - After on request rises, wait turn-on delay then start soft-start.
// - After on request falls, wait turn-off delay then disable output.
// - No new turn-on accepted until turn-off delay ends and output is off.
// - Registers load nonvolatile defaults at power-up; stored copies replaceable.
`timescale 1ns/1ns
module pg_window_and_onoff_delay_regs #(
   parameter int MIN_ON_WAIT_CYCLES = pg_delay_pkg::MIN_ON_WAIT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] option_register,
   input wire logic [1:0] follower,
   input wire logic nvm_load,
   input wire logic [1:0][1:0] nvm_threshold_select,
   input wire logic [1:0][2:0] nvm_on_delay_ratio,
   input wire logic [1:0][2:0] nvm_off_delay_ratio,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_page,
   input wire logic [7:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_nack,
   output logic [7:0] rsp_rdata,
   input wire logic fault_clear,
   output logic invalid_command_fault,
   output logic smbalert_b,
   input wire logic [1:0] on_request,
   input wire logic [1:0][pg_delay_pkg::RISE_W-1:0] soft_start_rise_time,
   output logic [1:0] output_enable,
   output logic [1:0] soft_start_begin,
   output logic [1:0][1:0] threshold_select,
   output logic [1:0][9:0] undervoltage_limit,
   output logic [1:0][9:0] pg_low_limit,
   output logic [1:0][9:0] pg_high_limit,
   output logic [1:0][9:0] overvoltage_limit,
   output logic [1:0][9:0] overvoltage_fixed_mv
);
   localparam int CW = pg_delay_pkg::COUNT_W;

   if (MIN_ON_WAIT_CYCLES < 1 || MIN_ON_WAIT_CYCLES >= 2 ** CW) begin : g_bad_wait
      $error("MIN_ON_WAIT_CYCLES does not fit the wait counter");
   end

   typedef struct packed {
      logic loaded;
      logic [1:0][1:0] pg_sel;
      logic [1:0][2:0] on_ratio;
      logic [1:0][2:0] off_ratio;
      pg_delay_pkg::seq_e [1:0] seq;
      logic [1:0][CW-1:0] count;
      logic [1:0] ssb;
      logic rsp_valid;
      logic rsp_nack;
      logic [7:0] rdata;
      logic fault;
   } state_s;

   state_s st;
   state_s next_st;
   logic is_cmd;
   logic [1:0] sel;
   logic follower_hit;
   logic nack;
   logic [1:0][CW-1:0] wait_on;
   logic [1:0][CW-1:0] wait_off;
   logic read_ch;

   always_comb begin
      is_cmd = cmd_code == pg_delay_pkg::CMD_PG_WINDOW || cmd_code == pg_delay_pkg::CMD_ON_OFF_DELAY;
      sel[0] = cmd_page == pg_delay_pkg::PAGE_CH1 || cmd_page == pg_delay_pkg::PAGE_BOTH;
      sel[1] = cmd_page == pg_delay_pkg::PAGE_CH2 || cmd_page == pg_delay_pkg::PAGE_BOTH;
      follower_hit = is_cmd && |(sel & follower);
      nack = !is_cmd || sel == 2'h0 || follower_hit;
      read_ch = !sel[0];
      for (int c = 0; c < 2; c++) begin
         wait_on[c] = follower[c] ? CW'(MIN_ON_WAIT_CYCLES) :
            CW'(st.on_ratio[c]) * CW'(soft_start_rise_time[c]);
         wait_off[c] = follower[c] ? '0 :
            CW'(st.off_ratio[c]) * CW'(soft_start_rise_time[c]);
      end
   end

   always_comb begin
      next_st = st;
      next_st.ssb = 2'h0;
      next_st.rsp_valid = cmd_valid;
      next_st.rsp_nack = cmd_valid && nack;
      next_st.rdata = 8'h00;
      // Load at reset release or on request, so a restore is seen at once
      if (!st.loaded || nvm_load) begin
         next_st.loaded = 1'b1;
         next_st.pg_sel = nvm_threshold_select;
         next_st.on_ratio = nvm_on_delay_ratio;
         next_st.off_ratio = nvm_off_delay_ratio;
      end
      if (cmd_valid && !nack && !cmd_write) begin
         if (cmd_code == pg_delay_pkg::CMD_PG_WINDOW) begin
            next_st.rdata = {6'h00, st.pg_sel[read_ch]};
         end else begin
            next_st.rdata = {st.on_ratio[read_ch], 1'b0, st.off_ratio[read_ch], 1'b0};
         end
      end
      for (int c = 0; c < 2; c++) begin
         // A both-page write still reaches the channel that is not a follower
         if (cmd_valid && cmd_write && is_cmd && sel[c] && !follower[c]) begin
            if (cmd_code == pg_delay_pkg::CMD_PG_WINDOW) begin
               next_st.pg_sel[c] = cmd_wdata[pg_delay_pkg::SEL_LSB +: 2];
            end else begin
               next_st.on_ratio[c] = cmd_wdata[pg_delay_pkg::ON_LSB +: 3];
               next_st.off_ratio[c] = cmd_wdata[pg_delay_pkg::OFF_LSB +: 3];
            end
         end
         unique case (st.seq[c])
            pg_delay_pkg::SEQ_OFF: begin
               if (on_request[c]) begin
                  if (wait_on[c] == '0) begin
                     next_st.seq[c] = pg_delay_pkg::SEQ_ON;
                     next_st.ssb[c] = 1'b1;
                  end else begin
                     next_st.seq[c] = pg_delay_pkg::SEQ_ON_WAIT;
                     next_st.count[c] = wait_on[c] - CW'(1);
                  end
               end
            end
            pg_delay_pkg::SEQ_ON_WAIT: begin
               if (!on_request[c]) begin
                  next_st.seq[c] = pg_delay_pkg::SEQ_OFF;
               end else if (st.count[c] == '0) begin
                  next_st.seq[c] = pg_delay_pkg::SEQ_ON;
                  next_st.ssb[c] = 1'b1;
               end else begin
                  next_st.count[c] = st.count[c] - CW'(1);
               end
            end
            pg_delay_pkg::SEQ_ON: begin
               if (!on_request[c]) begin
                  if (wait_off[c] == '0) begin
                     next_st.seq[c] = pg_delay_pkg::SEQ_OFF;
                  end else begin
                     next_st.seq[c] = pg_delay_pkg::SEQ_OFF_WAIT;
                     next_st.count[c] = wait_off[c] - CW'(1);
                  end
               end
            end
            pg_delay_pkg::SEQ_OFF_WAIT: begin
               // On request is not looked at here; a turn-on waits for off
               if (st.count[c] == '0) begin
                  next_st.seq[c] = pg_delay_pkg::SEQ_OFF;
               end else begin
                  next_st.count[c] = st.count[c] - CW'(1);
               end
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      if (fault_clear) begin
         next_st.fault = 1'b0;
      end
      if (cmd_valid && follower_hit) begin
         next_st.fault = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.pg_sel <= {2{pg_delay_pkg::PG_SEL_RESET}};
         st.on_ratio <= {2{pg_delay_pkg::RATIO_RESET}};
         st.off_ratio <= {2{pg_delay_pkg::RATIO_RESET}};
         st.seq <= '{default: pg_delay_pkg::SEQ_OFF};
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      pg_delay_pkg::limits_s l;
      l = '0;
      for (int c = 0; c < 2; c++) begin
         l = pg_delay_pkg::decode_limits(st.pg_sel[c], option_register[pg_delay_pkg::FIX_OV_BIT]);
         undervoltage_limit[c] = l.uv;
         pg_low_limit[c] = l.pg_low;
         pg_high_limit[c] = l.pg_high;
         overvoltage_limit[c] = l.ov;
         overvoltage_fixed_mv[c] = l.ov_mv;
         output_enable[c] = st.seq[c] == pg_delay_pkg::SEQ_ON || st.seq[c] == pg_delay_pkg::SEQ_OFF_WAIT;
      end
   end

   assign rsp_valid = st.rsp_valid;
   assign rsp_nack = st.rsp_nack;
   assign rsp_rdata = st.rdata;
   assign invalid_command_fault = st.fault;
   assign smbalert_b = !st.fault;
   assign soft_start_begin = st.ssb;
   assign threshold_select = st.pg_sel;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_follower_access;
      cmd_valid && is_cmd && sel[0] && follower[0];
   endsequence
   sequence s_flagged;
      rsp_valid && rsp_nack && invalid_command_fault && !smbalert_b;
   endsequence

   property p_follower_nack;
      s_follower_access |=> s_flagged;
   endproperty
   a_follower_nack: assert property (p_follower_nack) else $error("follower access not flagged");

   property p_follower_keeps;
      s_follower_access and (cmd_write && st.loaded && !nvm_load)
         |=> $stable(st.pg_sel[0]) && $stable(st.on_ratio[0]);
   endproperty
   a_follower_keeps: assert property (p_follower_keeps) else $error("follower write stored");

   property p_both_write;
      cmd_valid && cmd_write && cmd_code == pg_delay_pkg::CMD_ON_OFF_DELAY
         && cmd_page == pg_delay_pkg::PAGE_BOTH && follower == 2'h0 && !nvm_load
         |=> st.on_ratio[0] == $past(cmd_wdata[7:5]) && st.on_ratio[1] == $past(cmd_wdata[7:5]);
   endproperty
   a_both_write: assert property (p_both_write) else $error("both-page write missed a channel");

   property p_reserved_zero;
      cmd_valid && !cmd_write && cmd_code == pg_delay_pkg::CMD_ON_OFF_DELAY
         |=> rsp_rdata[4] == 1'b0 && rsp_rdata[0] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read non-zero");

   property p_follower_min_wait;
      st.seq[0] == pg_delay_pkg::SEQ_OFF && on_request[0] && follower[0]
         |=> st.seq[0] == pg_delay_pkg::SEQ_ON_WAIT && st.count[0] == CW'(MIN_ON_WAIT_CYCLES - 1);
   endproperty
   a_follower_min_wait: assert property (p_follower_min_wait) else $error("follower on wait wrong");

   property p_immediate_on;
      st.seq[0] == pg_delay_pkg::SEQ_OFF && on_request[0] && !follower[0] && st.on_ratio[0] == 3'h0
         |=> output_enable[0] && soft_start_begin[0] ##1 !soft_start_begin[0];
   endproperty
   a_immediate_on: assert property (p_immediate_on) else $error("zero on delay did not start");

   property p_on_wait_load;
      st.seq[0] == pg_delay_pkg::SEQ_OFF && on_request[0] && !follower[0] && wait_on[0] != '0
         |=> !output_enable[0] && st.count[0] == $past(wait_on[0]) - CW'(1);
   endproperty
   a_on_wait_load: assert property (p_on_wait_load) else $error("on wait miscounted");

   property p_immediate_off;
      st.seq[0] == pg_delay_pkg::SEQ_ON && !on_request[0] && wait_off[0] == '0 |=> !output_enable[0];
   endproperty
   a_immediate_off: assert property (p_immediate_off) else $error("zero off delay held output");

   property p_off_wait_holds;
      st.seq[0] == pg_delay_pkg::SEQ_OFF_WAIT && st.count[0] != '0
         |=> output_enable[0] && st.seq[0] == pg_delay_pkg::SEQ_OFF_WAIT && !soft_start_begin[0];
   endproperty
   a_off_wait_holds: assert property (p_off_wait_holds) else $error("turn-on during off wait");

   property p_fixed_ov;
      option_register[pg_delay_pkg::FIX_OV_BIT] && st.pg_sel[0][0]
         |-> overvoltage_fixed_mv[0] == pg_delay_pkg::OV_FIXED_700_MV && overvoltage_limit[0] == '0;
   endproperty
   a_fixed_ov: assert property (p_fixed_ov) else $error("fixed overvoltage limit wrong");

   property p_window_00;
      st.pg_sel[0] == 2'h0 && !option_register[pg_delay_pkg::FIX_OV_BIT]
         |-> undervoltage_limit[0] == 10'h358 && pg_high_limit[0] == 10'h07d && overvoltage_limit[0] == 10'h0a8;
   endproperty
   a_window_00: assert property (p_window_00) else $error("select 00 limits wrong");

   property p_window_1x;
      st.pg_sel[0][1] |-> undervoltage_limit[0] == 10'h2de && pg_low_limit[0] == 10'h31a;
   endproperty
   a_window_1x: assert property (p_window_1x) else $error("select 1x limits wrong");
endmodule : pg_window_and_onoff_delay_regs

// ==== pmbus_host_model.sv ====
/*
 PMBus host model: one register access per call of access().
 Assumes the block takes a request on one edge and answers one cycle later.
*/
`timescale 1ns/1ns
module pmbus_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_page,
   output logic [7:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic rsp_nack,
   input wire logic [7:0] rsp_rdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_page = 8'h00;
      cmd_wdata = 8'h00;
   end

   task automatic access(input logic w, input logic [7:0] code, input logic [7:0] page,
                         input logic [7:0] wd, output logic [1:0] rsp, output logic [7:0] rd);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_code <= code;
      cmd_page <= page;
      cmd_wdata <= wd;
      @(posedge clk);
      cmd_valid <= 1'b0;
      // Released lines flip so a stale request never looks valid
      cmd_code <= ~code;
      cmd_page <= ~page;
      cmd_wdata <= ~wd;
      #1;
      rsp = {rsp_valid, rsp_nack};
      rd = rsp_rdata;
   endtask : access
endmodule : pmbus_host_model

// ==== pg_window_and_onoff_delay_regs_test.sv ====
/*
 Self-checking bench for the paged window and delay registers.
 Assumes 100 MHz clock and rise times given in clock cycles.
*/
`timescale 1ns/1ns
module pg_window_and_onoff_delay_regs_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic nvm_load = 1'b0;
   logic fault_clear = 1'b0;
   logic [15:0] option_register = 16'h0000;
   logic [1:0] follower = 2'h0;
   logic [1:0] on_request = 2'h0;
   logic [1:0][1:0] nvm_sel;
   logic [1:0][2:0] nvm_on;
   logic [1:0][2:0] nvm_off;
   logic [1:0][19:0] rise;
   logic cmd_valid, cmd_write, rsp_valid, rsp_nack, fault, smbalert_b;
   logic [7:0] cmd_code, cmd_page, cmd_wdata, rsp_rdata, code, page, wd, rd;
   logic [1:0] output_enable, soft_start_begin, rsp;
   logic [1:0][1:0] threshold_select;
   logic [1:0][9:0] uv, pgl, pgh, ov, ovmv;
   logic [7:0] sh [2][2];
   int n_errors = 0;
   int n_checks = 0;
   int n, ch, c, p, a, b, i, fx;

   always #5 clk = ~clk;

   pmbus_host_model pmbus_host_model_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));

   pg_window_and_onoff_delay_regs #(.MIN_ON_WAIT_CYCLES(20)) pg_window_and_onoff_delay_regs_i (
      .clk(clk), .rst_b(rst_b), .option_register(option_register), .follower(follower),
      .nvm_load(nvm_load), .nvm_threshold_select(nvm_sel), .nvm_on_delay_ratio(nvm_on),
      .nvm_off_delay_ratio(nvm_off), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .fault_clear(fault_clear),
      .invalid_command_fault(fault), .smbalert_b(smbalert_b), .on_request(on_request),
      .soft_start_rise_time(rise), .output_enable(output_enable),
      .soft_start_begin(soft_start_begin), .threshold_select(threshold_select),
      .undervoltage_limit(uv), .pg_low_limit(pgl), .pg_high_limit(pgh),
      .overvoltage_limit(ov), .overvoltage_fixed_mv(ovmv));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic rw(input logic w, input logic [7:0] cd, input logic [7:0] pg, input logic [7:0] d);
      pmbus_host_model_i.access(w, cd, pg, d, rsp, rd);
   endtask : rw

   function automatic logic [49:0] lim(input logic [1:0] s, input logic f);
      lim = {10'(s[1] ? -290 : s[0] ? -120 : -168), 10'(s[1] ? -230 : s[0] ? -70 : -125),
             10'(s == 2'h0 ? 125 : 70), 10'(f ? 0 : s[0] ? 120 : 168),
             10'(!f ? 0 : s[0] ? 700 : 800)};
   endfunction : lim

   function automatic logic [7:0] mask(input logic [7:0] cd, input logic [7:0] v);
      mask = (cd == 8'hd7) ? (v & 8'h03) : (v & 8'hee);
   endfunction : mask

   // Drives the request level and counts edges until the output follows
   task automatic seq(input int k, input logic v, input int exp);
      @(posedge clk);
      on_request[k] <= v;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (output_enable[k] !== v && n < 500);
      check(n, exp);
      if (v) check(soft_start_begin[k], 1'b1);
   endtask : seq

   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      #300_000;
      n_errors++;
      print_verdict();
   end

   initial begin
      void'($urandom(40604));
      nvm_sel = 4'($urandom);
      nvm_on = 6'($urandom);
      nvm_off = 6'($urandom);
      rise = {20'h3, 20'h2};
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      for (ch = 0; ch < 2; ch++) begin
         rw(0, 8'hd7, 8'(ch), 8'h00);
         check({rsp, rd}, {2'b10, 6'h0, nvm_sel[ch]});
         rw(0, 8'hd8, 8'(ch), 8'h00);
         check({rsp, rd}, {2'b10, nvm_on[ch], 1'b0, nvm_off[ch], 1'b0});
      end
      nvm_sel <= ~nvm_sel;
      nvm_load <= 1'b1;
      @(posedge clk);
      nvm_load <= 1'b0;
      @(posedge clk);
      #1;
      check(threshold_select, nvm_sel);
      $display("test power-up image done");
      for (ch = 0; ch < 2; ch++) begin
         sh[0][ch] = {6'h0, nvm_sel[ch]};
         sh[1][ch] = {nvm_on[ch], 1'b0, nvm_off[ch], 1'b0};
      end
      for (i = 0; i < 16; i++) begin
         c = $urandom_range(0, 1);
         code = c ? 8'hd8 : 8'hd7;
         p = $urandom_range(0, 2);
         page = (p == 2) ? 8'h11 : 8'(p);
         wd = 8'($urandom);
         rw(1, code, page, wd);
         check({rsp, rd}, {2'b10, 8'h00});
         for (ch = 0; ch < 2; ch++) if (page == 8'(ch) || page == 8'h11) sh[c][ch] = mask(code, wd);
         ch = $urandom_range(0, 1);
         rw(0, code, 8'(ch), 8'h00);
         check({rsp, rd}, {2'b10, sh[c][ch]});
      end
      rw(0, 8'hd7, 8'h11, 8'h00);
      check({rsp, rd}, {2'b10, sh[0][0]});
      rw(0, 8'hd9, 8'h00, 8'h00);
      check({rsp, fault}, 3'b110);
      $display("test paged access done");
      for (i = 0; i < 8; i++) begin
         fx = i[0];
         @(posedge clk);
         option_register <= (16'($urandom) & 16'hdfff) | (16'(fx) << 13);
         rw(1, 8'hd7, 8'h11, {6'($urandom), i[2:1]});
         for (ch = 0; ch < 2; ch++)
            check({uv[ch], pgl[ch], pgh[ch], ov[ch], ovmv[ch]}, lim(i[2:1], fx[0]));
      end
      sh[0][0] = 8'h03;
      sh[0][1] = 8'h03;
      $display("test threshold decode done");
      @(posedge clk);
      follower <= 2'b10;
      rw(1, 8'hd7, 8'h01, 8'h00);
      check({rsp, fault, smbalert_b}, 4'b1110);
      rw(0, 8'hd8, 8'h01, 8'h00);
      check(rsp, 2'b11);
      rw(1, 8'hd7, 8'h11, 8'h02);
      check({rsp, threshold_select}, {2'b11, 2'h3, 2'h2});
      @(posedge clk);
      fault_clear <= 1'b1;
      @(posedge clk);
      fault_clear <= 1'b0;
      #1;
      check({fault, smbalert_b}, 2'b01);
      $display("test follower lockout done");
      a = $urandom_range(1, 7);
      b = $urandom_range(1, 7);
      rw(1, 8'hd8, 8'h00, {3'(a), 1'b1, 3'(b), 1'b1});
      seq(0, 1'b1, a * 2 + 1);
      seq(0, 1'b0, b * 2 + 1);
      rw(1, 8'hd8, 8'h00, 8'h06);
      seq(0, 1'b1, 1);
      @(posedge clk);
      on_request[0] <= 1'b0;
      repeat (3) @(posedge clk);
      // Request during the off wait on purpose; it must not cut the wait short
      on_request[0] <= 1'b1;
      n = 3;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (output_enable[0] !== 1'b0 && n < 500);
      check(n, 7);
      @(posedge clk);
      #1;
      check(output_enable[0], 1'b1);
      seq(0, 1'b0, 7);
      seq(1, 1'b1, 21);
      seq(1, 1'b0, 1);
      // Channel one as follower instead of channel two, so its own lockout and forced waits are seen
      follower <= 2'b01;
      rw(1, 8'hd7, 8'h00, 8'h01);
      check({rsp, threshold_select[0]}, {2'b11, 2'h2});
      seq(0, 1'b1, 21);
      seq(0, 1'b0, 1);
      $display("test sequencer done");
      print_verdict();
   end
endmodule : pg_window_and_onoff_delay_regs_test
